// >>> rsm_pkg.sv
// Purpose: shared constants and carriers of the radio serial master port
// Assumes: byte-wide special-function register access, 8-bit addresses
// Notes:   field positions are bit indices inside the 8-bit registers
package rsm_pkg;

  // register addresses on the special-function bus
  localparam logic [7:0] CFG_ADDR  = 8'h84;
  localparam logic [7:0] RATE_ADDR = 8'h85;
  localparam logic [7:0] DATA_ADDR = 8'h86;
  localparam logic [7:0] CTL_ADDR  = 8'hb0;

  // configuration register fields
  localparam int CFG_BUSY_BIT  = 7;
  localparam int CFG_MASTER_ENABLE_BIT = 6;
  localparam int CFG_CPHA_BIT  = 5;
  localparam int CFG_CPOL_BIT  = 4;
  localparam logic [3:0] CFG_LOW_VAL = 4'h7;

  // control register fields
  localparam int CTL_DONE_BIT = 7;
  localparam int CTL_WRITE_COLLISION_FLAG_BIT = 6;
  localparam int CTL_MODE_FAULT_FLAG_BIT = 5;
  localparam int CTL_RSVD_BIT = 4;
  localparam int CTL_NSS_HI   = 3;
  localparam int CTL_NSS_LO   = 2;
  localparam int CTL_TXE_BIT  = 1;
  localparam int CTL_EN_BIT   = 0;

  // reset values and encodings
  localparam logic [1:0] NSS_MODE_RESET = 2'h1;
  localparam logic [1:0] NSS_MODE_FAULT = 2'h1;
  localparam logic [7:0] RATE_RESET     = 8'h00;
  localparam logic [7:0] BYTE_ZERO      = 8'h00;
  localparam logic [2:0] LAST_BIT       = 3'h7;

  typedef struct packed {
    logic master_enable;
    logic clock_phase_sel;
    logic clock_idle_level;
  } rsm_cfg_s;

  typedef struct packed {
    logic       transfer_done_flag;
    logic       write_collision_flag;
    logic       mode_fault_flag;
    logic [1:0] select_mode_field;
    logic       port_enable;
  } rsm_ctl_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rsm_sfr_req_s;

  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_SHIFT = 1'b1
  } rsm_state_e;

endpackage

// >>> rsm_sync3.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs asynchronous to clock
// Notes:   output moves only when stages two and three agree
module rsm_sync3 #(
  parameter int         WIDTH     = 2,
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  if (WIDTH < 1 || WIDTH > 8) begin : g_chk
    $error("rsm_sync3: WIDTH must be 1 to 8");
  end

  logic [WIDTH-1:0] ff1_reg;
  logic [WIDTH-1:0] ff2_reg;
  logic [WIDTH-1:0] ff3_reg;
  logic [WIDTH-1:0] out_reg;
  logic [WIDTH-1:0] agree;
  logic [WIDTH-1:0] out_next;

  // per bit: follow stage three only where two and three match
  assign agree    = ~(ff2_reg ^ ff3_reg);
  assign out_next = (agree & ff3_reg) | (~agree & out_reg);
  assign sync_out = out_reg;

  // stage one feeds stage two only, nothing else reads it
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ff1_reg <= RESET_VAL[WIDTH-1:0];
      ff2_reg <= RESET_VAL[WIDTH-1:0];
      ff3_reg <= RESET_VAL[WIDTH-1:0];
      out_reg <= RESET_VAL[WIDTH-1:0];
    end else begin
      ff1_reg <= async_in;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
      out_reg <= out_next;
    end
  end

endmodule

// >>> rsm_radio_spi_master_ctrl.sv
// Purpose: byte-wide serial master port towards the radio transceiver
// Assumes: one core_clock domain, special-function register strobes
// Notes:   three-wire master only; slave select is never driven here
// Operation
// [R01] busy bit high while a transfer runs
// [R02] master_enable selects master operation
// [R03] phase selects first or second edge centring
// [R04] idle level sets serial clock idle state
// [R05] config low nibble reads 0111, writes ignored
// [R06] sample input one cycle before bit end
// [R07] done flag set at transfer end, software clears
// [R08] data write while buffer full sets collision
// [R09] colliding write discarded, buffer kept
// [R10] select low plus mode 01 sets fault
// [R11] enabled interrupt from any sticky flag
// [R12] reserved control bit reads unspecified, write 0
// [R13] software programs select mode to 00
// [R14] accepted byte clears buffer-empty
// [R15] move into shift register sets buffer-empty
// [R16] port_enable turns the port on
// [R17] data write starts transfer, read returns receive
// [R18] clock rate is core clock over 2(rate+1)
// [R19] most significant bit first both directions
module rsm_radio_spi_master_ctrl (
  input  wire logic                 clock,
  input  wire logic                 nrst,
  input  wire rsm_pkg::rsm_sfr_req_s sfr_req,
  output logic      [7:0]           sfr_rdata,
  input  wire logic                 irq_enable,
  output logic                      spi_irq,
  output logic                      sck,
  output logic                      mosi,
  input  wire logic                 miso,
  input  wire logic                 nss_in_n
);

  // sticky flag update; a hardware set beats a software write of 0
  function automatic logic flag_upd(
    input logic cur,
    input logic set,
    input logic wr,
    input logic wbit
  );
    return set | (wr ? wbit : cur);
  endfunction

  rsm_pkg::rsm_cfg_s   cfg_reg;
  rsm_pkg::rsm_cfg_s   cfg_next;
  rsm_pkg::rsm_ctl_s   ctl_reg;
  rsm_pkg::rsm_ctl_s   ctl_next;
  rsm_pkg::rsm_state_e state_reg;
  rsm_pkg::rsm_state_e state_next;
  logic [7:0]          rate_reg;
  logic [7:0]          txbuf_reg;
  logic [7:0]          txbuf_next;
  logic                tx_empty_reg;
  logic                tx_empty_next;
  logic [7:0]          rxbuf_reg;
  logic [7:0]          rxbuf_next;
  logic [7:0]          shift_reg;
  logic [7:0]          shift_next;
  logic [7:0]          shifted;
  logic [7:0]          cnt_reg;
  logic [7:0]          cnt_next;
  logic                half_reg;
  logic                half_next;
  logic [2:0]          bit_reg;
  logic [2:0]          bit_next;
  logic                sck_reg;
  logic                sck_next;
  logic [7:0]          rdata_reg;
  logic [7:0]          rdata_next;
  logic [7:0]          rd_mux;
  logic [1:0]          pin_sync;
  logic                miso_s;
  logic                nss_s_n;
  logic                wr_cfg;
  logic                wr_rate;
  logic                wr_data;
  logic                wr_ctl;
  logic                active;
  logic                shifting;
  logic                half_end;
  logic                bit_end;
  logic                last_bit;
  logic                start;
  logic                accept;
  logic                done_set;
  logic                write_collision_flag_set;
  logic                mode_fault_flag_set;
  logic [7:0]          cfg_rd;
  logic [7:0]          ctl_rd;

  // pins from the radio pass the three-stage filter
  rsm_sync3 #(
    .WIDTH     (2),
    .RESET_VAL (8'h01)
  ) u_sync (
    .clock    (clock),
    .nrst     (nrst),
    .async_in ({miso, nss_in_n}),
    .sync_out (pin_sync)
  );

  assign miso_s  = pin_sync[1];
  assign nss_s_n = pin_sync[0];

  // write strobes per register
  assign wr_cfg  = sfr_req.wr && (sfr_req.addr == rsm_pkg::CFG_ADDR);
  assign wr_rate = sfr_req.wr && (sfr_req.addr == rsm_pkg::RATE_ADDR);
  assign wr_data = sfr_req.wr && (sfr_req.addr == rsm_pkg::DATA_ADDR);
  assign wr_ctl  = sfr_req.wr && (sfr_req.addr == rsm_pkg::CTL_ADDR);

  // port runs only with both master and port enable set
  assign active   = cfg_reg.master_enable & ctl_reg.port_enable; // [R02] [R16]
  assign shifting = (state_reg == rsm_pkg::ST_SHIFT);

  // divider: each half of a bit lasts rate+1 cycles
  assign half_end = shifting && (cnt_reg == rate_reg); // [R18]
  assign bit_end  = half_end & half_reg;
  assign last_bit = bit_end && (bit_reg == rsm_pkg::LAST_BIT);

  // a full buffer starts a byte when idle or right after the last bit
  assign start  = active & ~tx_empty_reg & (~shifting | last_bit); // [R17]
  assign accept = wr_data & tx_empty_reg; // [R14]

  // input bit enters at the bottom, msb leaves first
  assign shifted = {shift_reg[6:0], miso_s}; // [R19]

  // event sources for the sticky flags
  assign done_set = last_bit & active; // [R07]
  assign write_collision_flag_set = wr_data & ~tx_empty_reg; // [R08]
  assign mode_fault_flag_set = ~nss_s_n & cfg_reg.master_enable
                  & (ctl_reg.select_mode_field == rsm_pkg::NSS_MODE_FAULT); // [R10]

  // sequencer: disabling the port aborts a byte at once
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      rsm_pkg::ST_IDLE: begin
        if (start) begin
          state_next = rsm_pkg::ST_SHIFT;
        end
      end
      rsm_pkg::ST_SHIFT: begin
        if (!active) begin
          state_next = rsm_pkg::ST_IDLE;
        end else if (last_bit && !start) begin
          state_next = rsm_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = rsm_pkg::ST_IDLE;
      end
    endcase
  end

  // half-period counter and bit position
  always_comb begin
    cnt_next  = cnt_reg;
    half_next = half_reg;
    bit_next  = bit_reg;
    if (start || !shifting || !active) begin
      cnt_next  = rsm_pkg::BYTE_ZERO;
      half_next = 1'b0;
      bit_next  = 3'h0;
    end else if (half_end) begin
      cnt_next  = rsm_pkg::BYTE_ZERO;
      half_next = ~half_reg;
      bit_next  = half_reg ? bit_reg + 3'h1 : bit_reg;
    end else begin
      cnt_next  = cnt_reg + 8'h01;
    end
  end

  // shift path; sampling on the final cycle of each bit
  always_comb begin
    shift_next = shift_reg;
    rxbuf_next = rxbuf_reg;
    if (bit_end && active) begin
      shift_next = shifted; // [R06]
    end
    if (done_set) begin
      rxbuf_next = shifted; // [R17]
    end
    if (start) begin
      shift_next = txbuf_reg;
    end
  end

  // transmit buffer; a rejected write leaves it untouched
  always_comb begin
    txbuf_next    = txbuf_reg;
    tx_empty_next = tx_empty_reg;
    if (accept) begin
      txbuf_next    = sfr_req.wdata; // [R09]
      tx_empty_next = 1'b0; // [R14]
    end else if (start) begin
      tx_empty_next = 1'b1; // [R15]
    end
  end

  // serial clock: idle level, toggled by half and phase while shifting
  always_comb begin
    if (state_next == rsm_pkg::ST_SHIFT) begin
      sck_next = cfg_reg.clock_idle_level ^ half_next ^ cfg_reg.clock_phase_sel; // [R03]
    end else begin
      sck_next = cfg_reg.clock_idle_level; // [R04]
    end
  end

  // configuration write; busy and low nibble are not writable
  always_comb begin
    cfg_next = cfg_reg;
    if (wr_cfg) begin
      cfg_next.master_enable    = sfr_req.wdata[rsm_pkg::CFG_MASTER_ENABLE_BIT];
      cfg_next.clock_phase_sel  = sfr_req.wdata[rsm_pkg::CFG_CPHA_BIT];
      cfg_next.clock_idle_level = sfr_req.wdata[rsm_pkg::CFG_CPOL_BIT];
    end
  end

  // control write and flag events; the reserved bit is not stored
  always_comb begin
    ctl_next = ctl_reg;
    ctl_next.transfer_done_flag = flag_upd(ctl_reg.transfer_done_flag, done_set,
      wr_ctl, sfr_req.wdata[rsm_pkg::CTL_DONE_BIT]); // [R07]
    ctl_next.write_collision_flag = flag_upd(ctl_reg.write_collision_flag, write_collision_flag_set,
      wr_ctl, sfr_req.wdata[rsm_pkg::CTL_WRITE_COLLISION_FLAG_BIT]); // [R08]
    ctl_next.mode_fault_flag = flag_upd(ctl_reg.mode_fault_flag, mode_fault_flag_set,
      wr_ctl, sfr_req.wdata[rsm_pkg::CTL_MODE_FAULT_FLAG_BIT]); // [R10]
    if (wr_ctl) begin
      ctl_next.select_mode_field =
        sfr_req.wdata[rsm_pkg::CTL_NSS_HI:rsm_pkg::CTL_NSS_LO];
      ctl_next.port_enable = sfr_req.wdata[rsm_pkg::CTL_EN_BIT]; // [R16]
    end
  end

  // read images of the two mixed registers
  always_comb begin
    cfg_rd = rsm_pkg::BYTE_ZERO;
    cfg_rd[rsm_pkg::CFG_BUSY_BIT]  = shifting; // [R01]
    cfg_rd[rsm_pkg::CFG_MASTER_ENABLE_BIT] = cfg_reg.master_enable;
    cfg_rd[rsm_pkg::CFG_CPHA_BIT]  = cfg_reg.clock_phase_sel;
    cfg_rd[rsm_pkg::CFG_CPOL_BIT]  = cfg_reg.clock_idle_level;
    cfg_rd[3:0] = rsm_pkg::CFG_LOW_VAL; // [R05]
  end

  always_comb begin
    ctl_rd = rsm_pkg::BYTE_ZERO;
    ctl_rd[rsm_pkg::CTL_DONE_BIT] = ctl_reg.transfer_done_flag;
    ctl_rd[rsm_pkg::CTL_WRITE_COLLISION_FLAG_BIT] = ctl_reg.write_collision_flag;
    ctl_rd[rsm_pkg::CTL_MODE_FAULT_FLAG_BIT] = ctl_reg.mode_fault_flag;
    ctl_rd[rsm_pkg::CTL_RSVD_BIT] = 1'b0; // [R12]
    ctl_rd[rsm_pkg::CTL_NSS_HI:rsm_pkg::CTL_NSS_LO] = ctl_reg.select_mode_field;
    ctl_rd[rsm_pkg::CTL_TXE_BIT]  = tx_empty_reg;
    ctl_rd[rsm_pkg::CTL_EN_BIT]   = ctl_reg.port_enable;
  end

  // read decode; unmapped addresses answer zero
  always_comb begin
    if (sfr_req.addr == rsm_pkg::CFG_ADDR) begin
      rd_mux = cfg_rd;
    end else if (sfr_req.addr == rsm_pkg::RATE_ADDR) begin
      rd_mux = rate_reg;
    end else if (sfr_req.addr == rsm_pkg::DATA_ADDR) begin
      rd_mux = rxbuf_reg; // [R17]
    end else if (sfr_req.addr == rsm_pkg::CTL_ADDR) begin
      rd_mux = ctl_rd;
    end else begin
      rd_mux = rsm_pkg::BYTE_ZERO;
    end
  end

  // read data held until the next read strobe
  assign rdata_next = sfr_req.rd ? rd_mux : rdata_reg;

  // outputs; interrupt is a level while any flag stands and irq_enable is high
  assign sfr_rdata = rdata_reg;
  assign sck       = sck_reg;
  assign mosi      = shift_reg[7]; // [R19]
  assign spi_irq   = irq_enable & (ctl_reg.transfer_done_flag
                   | ctl_reg.write_collision_flag | ctl_reg.mode_fault_flag); // [R11]

  // register file
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cfg_reg  <= '0;
      ctl_reg  <= '{1'b0, 1'b0, 1'b0, rsm_pkg::NSS_MODE_RESET, 1'b0};
      rate_reg <= rsm_pkg::RATE_RESET;
    end else begin
      cfg_reg  <= cfg_next;
      ctl_reg  <= ctl_next;
      rate_reg <= wr_rate ? sfr_req.wdata : rate_reg; // [R18]
    end
  end

  // buffers and read data
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      txbuf_reg    <= rsm_pkg::BYTE_ZERO;
      tx_empty_reg <= 1'b1;
      rxbuf_reg    <= rsm_pkg::BYTE_ZERO;
      rdata_reg    <= rsm_pkg::BYTE_ZERO;
    end else begin
      txbuf_reg    <= txbuf_next;
      tx_empty_reg <= tx_empty_next;
      rxbuf_reg    <= rxbuf_next;
      rdata_reg    <= rdata_next;
    end
  end

  // serial engine; clock idles low out of reset
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= rsm_pkg::ST_IDLE;
      shift_reg <= rsm_pkg::BYTE_ZERO;
      cnt_reg   <= rsm_pkg::BYTE_ZERO;
      half_reg  <= 1'b0;
      bit_reg   <= 3'h0;
      sck_reg   <= 1'b0;
    end else begin
      state_reg <= state_next; // [R01]
      shift_reg <= shift_next;
      cnt_reg   <= cnt_next;
      half_reg  <= half_next;
      bit_reg   <= bit_next;
      sck_reg   <= sck_next;
    end
  end

endmodule

// >>> rsm_chk_sva.sv
// Purpose: port-level checks of the radio serial master
// Assumes: field shadows tracked from register write strobes
// Notes:   half-period check is a lower bound; aborts not covered
module rsm_chk (
  input wire logic                  clock,
  input wire logic                  nrst,
  input wire rsm_pkg::rsm_sfr_req_s sfr_req,
  input wire logic [7:0]            sfr_rdata,
  input wire logic                  irq_enable,
  input wire logic                  spi_irq,
  input wire logic                  sck,
  input wire logic                  mosi,
  input wire logic                  miso,
  input wire logic                  nss_in_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic [8:0] rate_reg;
  logic [8:0] run_reg;
  logic       pol_reg;
  logic       pha_reg;
  logic       en_reg;
  logic       sck_reg;
  // register selects seen on the bus
  wire cfg_w  = sfr_req.wr && sfr_req.addr == rsm_pkg::CFG_ADDR;
  wire ctl_w  = sfr_req.wr && sfr_req.addr == rsm_pkg::CTL_ADDR;
  wire rate_w = sfr_req.wr && sfr_req.addr == rsm_pkg::RATE_ADDR;
  wire cfg_r  = sfr_req.rd && sfr_req.addr == rsm_pkg::CFG_ADDR;
  wire ctl_r  = sfr_req.rd && sfr_req.addr == rsm_pkg::CTL_ADDR;
  // shadows; run_reg saturates so idle gaps never look short
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rate_reg <= 9'h001;
      run_reg  <= 9'h1ff;
      pol_reg  <= 1'b0;
      pha_reg  <= 1'b0;
      en_reg   <= 1'b0;
      sck_reg  <= 1'b0;
    end else begin
      if (rate_w) rate_reg <= {1'b0, sfr_req.wdata} + 9'h001;
      if (cfg_w) pha_reg <= sfr_req.wdata[rsm_pkg::CFG_CPHA_BIT];
      if (cfg_w) pol_reg <= sfr_req.wdata[rsm_pkg::CFG_CPOL_BIT];
      if (ctl_w) en_reg <= sfr_req.wdata[rsm_pkg::CTL_EN_BIT];
      sck_reg <= sck;
      run_reg <= (sck != sck_reg) ? 9'h001 : run_reg + {8'h00, run_reg != 9'h1ff};
    end
  end
  AST_CFG_LOW: assert property (cfg_r |=> sfr_rdata[3:0] == rsm_pkg::CFG_LOW_VAL)
    else $error("config low nibble wrong");
  AST_RSVD_ZERO: assert property (ctl_r |=> !sfr_rdata[rsm_pkg::CTL_RSVD_BIT])
    else $error("reserved control bit not zero");
  AST_RDATA_HOLD: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  AST_IRQ_GATE: assert property (!irq_enable |-> !spi_irq)
    else $error("interrupt while disabled");
  AST_IRQ_STICKY: assert property (spi_irq && !sfr_req.wr ##1 irq_enable |-> spi_irq)
    else $error("flag cleared by hardware");
  AST_HALF_MIN: assert property (sck != sck_reg |-> run_reg >= rate_reg)
    else $error("serial clock half period too short");
  AST_MOSI_EDGE: assert property (!$stable(mosi) && !pha_reg |-> sck == pol_reg)
    else $error("data changed away from bit start");
  AST_IDLE_LVL: assert property (cfg_w && !en_reg |->
    ##3 sck == $past(sfr_req.wdata[rsm_pkg::CFG_CPOL_BIT], 3))
    else $error("idle clock level wrong");
  cover property ($rose(spi_irq));
  cover property (sck != sck_reg);
  cover property (cfg_w && sfr_req.wdata[rsm_pkg::CFG_CPOL_BIT]);
  cover property (cfg_w && sfr_req.wdata[rsm_pkg::CFG_CPHA_BIT]);
endmodule

bind rsm_radio_spi_master_ctrl rsm_chk rsm_chk_inst (
  .clock(clock), .nrst(nrst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
  .irq_enable(irq_enable), .spi_irq(spi_irq), .sck(sck), .mosi(mosi),
  .miso(miso), .nss_in_n(nss_in_n));

// >>> rsm_radio_model.sv
// Purpose: behavioural radio transceiver on the serial link
// Assumes: idle level 0, either clock phase, slave always selected
// Notes:   same reply byte every frame; phase may change only between bytes
module rsm_radio_model (
  input  wire logic       nrst,
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       phase,
  input  wire logic [7:0] reply,
  output logic            miso,
  output logic [7:0]      rx_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  int         fall_cnt = 0;
  int         rise_cnt = 0;
  int         cap_cnt  = 0;
  logic [7:0] rx_sh    = 8'h00;
  // phase 0: next bit after each trailing edge; phase 1: on each leading edge
  assign miso = phase ? reply[3'(8 - rise_cnt)] : reply[3'(7 - fall_cnt)];
  // one capture per bit, first bit lands in bit 7
  task automatic capture;
    rx_sh = {rx_sh[6:0], mosi};
    if (cap_cnt == 7) rx_byte = rx_sh;
    cap_cnt = (cap_cnt == 7) ? 0 : cap_cnt + 1;
  endtask
  // capture mid-bit: leading edge in phase 0, trailing edge in phase 1
  always @(sck or negedge nrst) begin
    if (!nrst) begin
      fall_cnt = 0;
      rise_cnt = 0;
      cap_cnt  = 0;
      rx_byte  = 8'h00;
    end else if (sck) begin
      rise_cnt = (rise_cnt == 7) ? 0 : rise_cnt + 1;
      if (!phase) capture();
    end else begin
      fall_cnt = (fall_cnt == 7) ? 0 : fall_cnt + 1;
      if (phase) capture();
    end
  end
endmodule

// >>> rsm_radio_spi_master_ctrl_bench.sv
// Purpose: self-checking bench of the radio serial master
// Assumes: data traffic with idle level 0, both clock phases
// Notes:   rate 3 keeps the miso sync delay inside one half bit
module rsm_radio_spi_master_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  clock;
  logic                  nrst;
  rsm_pkg::rsm_sfr_req_s sfr_req;
  logic [7:0]            sfr_rdata;
  logic                  irq_enable;
  logic                  spi_irq;
  logic                  sck;
  logic                  mosi;
  logic                  miso;
  logic                  nss_in_n;
  logic                  pha;
  logic [7:0]            rx_byte;
  logic [7:0]            v;
  int                    n_errors;
  int                    checked;

  rsm_radio_spi_master_ctrl rsm_radio_spi_master_ctrl_inst (
    .clock(clock), .nrst(nrst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .irq_enable(irq_enable), .spi_irq(spi_irq), .sck(sck), .mosi(mosi),
    .miso(miso), .nss_in_n(nss_in_n));
  rsm_radio_model rsm_radio_model_inst (.nrst(nrst), .sck(sck), .mosi(mosi),
    .phase(pha), .reply(8'hc5), .miso(miso), .rx_byte(rx_byte));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", name, exp, seen);
    end
  endtask

  // one-cycle strobes, then two idle cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1 sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    #1 sfr_req.wr = 1'b0;
    repeat (2) @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    #1 sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    #1 sfr_req.rd = 1'b0;
    d = sfr_rdata;
  endtask

  // bounded poll; 60 two-cycle reads span 120 cycles, not quite two 64-cycle bytes
  task automatic wait_done(output logic [7:0] d);
    d = 8'h00;
    for (int i = 0; i < 60 && d[7] !== 1'b1; i++) rd(rsm_pkg::CTL_ADDR, d);
    chk("done", d[7], 1'b1);
  endtask

  task automatic t_regs;
    rd(rsm_pkg::CFG_ADDR, v);
    chk("cfg_rst", v, 8'h07);
    rd(rsm_pkg::CTL_ADDR, v);
    chk("ctl_rst", v, 8'h06);
    rd(rsm_pkg::DATA_ADDR, v);
    chk("data_rst", v, 8'h00);
    rd(8'h87, v);
    chk("unmapped", v, 8'h00);
    wr(rsm_pkg::CFG_ADDR, 8'hcf);
    rd(rsm_pkg::CFG_ADDR, v);
    chk("cfg_wr", v, 8'h47);
    wr(rsm_pkg::RATE_ADDR, 8'h03);
    rd(rsm_pkg::RATE_ADDR, v);
    chk("rate", v, 8'h03);
  endtask

  // three writes: one shifts, one waits, one collides
  task automatic t_xfer;
    irq_enable = 1'b1;
    wr(rsm_pkg::CTL_ADDR, 8'h00);
    wr(rsm_pkg::DATA_ADDR, 8'h1e);
    rd(rsm_pkg::CFG_ADDR, v);
    chk("idle_off", v, 8'h47);
    rd(rsm_pkg::CTL_ADDR, v);
    chk("tx_full", v, 8'h00);
    wr(rsm_pkg::CTL_ADDR, 8'h01);
    rd(rsm_pkg::CFG_ADDR, v);
    chk("busy", v, 8'hc7);
    wr(rsm_pkg::DATA_ADDR, 8'h2d);
    wr(rsm_pkg::DATA_ADDR, 8'hf0);
    wait_done(v);
    chk("flags", v & 8'he0, 8'hc0);
    chk("irq_done", spi_irq, 1'b1);
    rd(rsm_pkg::DATA_ADDR, v);
    chk("rx1", v, 8'hc5);
    chk("tx1", rx_byte, 8'h1e);
    wr(rsm_pkg::CTL_ADDR, 8'h01);
    wait_done(v);
    rd(rsm_pkg::DATA_ADDR, v);
    chk("rx2", v, 8'hc5);
    chk("tx2", rx_byte, 8'h2d);
    rd(rsm_pkg::CFG_ADDR, v);
    chk("idle_end", v, 8'h47);
    rd(rsm_pkg::CTL_ADDR, v);
    chk("ctl_end", v, 8'h83);
  endtask

  // phase 1: data launched on the leading edge, one byte both ways
  task automatic t_pha;
    pha = 1'b1;
    wr(rsm_pkg::CFG_ADDR, 8'h60);
    wr(rsm_pkg::CTL_ADDR, 8'h01);
    wr(rsm_pkg::DATA_ADDR, 8'h93);
    wait_done(v);
    rd(rsm_pkg::DATA_ADDR, v);
    chk("rx_pha", v, 8'hc5);
    chk("tx_pha", rx_byte, 8'h93);
    rd(rsm_pkg::CFG_ADDR, v);
    chk("cfg_pha", v, 8'h67);
  endtask

  task automatic t_mode_fault_flag;
    nss_in_n = 1'b0;
    wr(rsm_pkg::CTL_ADDR, 8'h05);
    repeat (6) @(posedge clock);
    rd(rsm_pkg::CTL_ADDR, v);
    chk("mode_fault_flag", v, 8'h27);
    chk("irq_mode_fault_flag", spi_irq, 1'b1);
    irq_enable = 1'b0;
    nss_in_n   = 1'b1;
    #1 chk("irq_mask", spi_irq, 1'b0);
    repeat (6) @(posedge clock);
    wr(rsm_pkg::CTL_ADDR, 8'h01);
    rd(rsm_pkg::CTL_ADDR, v);
    chk("mode_fault_flag_clr", v, 8'h03);
  endtask

  // last: the idle-level swing would disturb the radio model's count
  task automatic t_pol;
    wr(rsm_pkg::CTL_ADDR, 8'h00);
    wr(rsm_pkg::CFG_ADDR, 8'h10);
    @(posedge clock);
    #1 chk("sck_hi", sck, 1'b1);
    wr(rsm_pkg::CFG_ADDR, 8'h00);
    @(posedge clock);
    #1 chk("sck_lo", sck, 1'b0);
  endtask

  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    sfr_req = '0;
    nrst = 1'b0;
    irq_enable = 1'b0;
    nss_in_n = 1'b1;
    pha = 1'b0;
    n_errors = 0;
    checked = 0;
    repeat (2) @(posedge clock);
    #1 nrst = 1'b1;
    t_regs;
    t_xfer;
    t_pha;
    t_mode_fault_flag;
    t_pol;
    close_out;
  end

  // watchdog, far beyond the roughly 300 cycles needed
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    close_out;
  end
endmodule
